// file: src/radio_mode_pkg.sv
// Function
// (RULE_01) Start-up ends in standby, the hub state
// (RULE_02) RC clock, supply check, crystal, interrupt
// (RULE_03) Deep-sleep bit stops clocks, keeps registers
// (RULE_04) Slow-standby bit: crystal low, clock 400 kHz
// (RULE_05) Standby runs crystal only
// (RULE_06) Transmit entered only from standby; code also enters it from receive to send an ack
// (RULE_07) After packet: standby, or receive for ack
// (RULE_08) Receive entered only from standby; code also enters it from transmit to await an ack
// (RULE_09) Receive until exit; ack after good packet
// (RULE_10) Radio ready within programmed warm-up time
// (RULE_11) Receive-transmit turnaround takes 150 us
// (RULE_12) Three-bit level selects eight output levels
// (RULE_13) Channel above 39 is clamped to 39
// (RULE_14) Frequency is 2402 plus twice channel MHz
// (RULE_15) Four-bit strength readable after measurement done
// (RULE_16) Fixed air rate of one megabit
// (RULE_17) Modulation BT 0.5, index 0.5
// (RULE_18) Clearing power bit returns to standby
package radio_mode_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TURN_US         = 150;
  localparam int unsigned TURN_CYC        = TURN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WARMUP_UNIT_US  = 1;
  localparam int unsigned WARMUP_UNIT_CYC = WARMUP_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SLOW_CLK_HZ     = 400_000;
  localparam int unsigned SLOW_DIV        = CLK_HZ / SLOW_CLK_HZ / 2;
  localparam int unsigned AIR_RATE_HZ     = 1_000_000;
  localparam int unsigned BIT_CYC         = CLK_HZ / AIR_RATE_HZ;
  localparam int unsigned GFSK_BT_X10     = 5;
  localparam int unsigned GFSK_IDX_X10    = 5;
  localparam logic [5:0]  CHAN_MAX        = 6'h27;
  localparam logic [11:0] FREQ_BASE_MHZ   = 12'h962;
  localparam logic [5:0]  CHAN_RST        = 6'h00;
  localparam logic [2:0]  LEVEL_RST       = 3'h6;
  localparam logic [7:0]  WARMUP_RST      = 8'h96;
  localparam logic [3:0]  RSSI_RST        = 4'h0;
  localparam int unsigned RSSI_AVG_LOG2   = 4;
  typedef enum logic [2:0] {
    MODE_STARTUP, MODE_STANDBY, MODE_SLEEP, MODE_SLOW,
    MODE_TX, MODE_RX
  } mode_t;
  typedef enum logic [1:0] {SU_RC, SU_XTAL, SU_DONE} startup_t;
endpackage

// file: src/packet_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module packet_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;
  logic [AW:0]      count_nxt;
  logic             ready_r;
  assign in_ready_out  = ready_r;
  assign count_nxt     = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// file: src/rssi_meter.sv
`timescale 1ns/1ps
`default_nettype none
module rssi_meter
  import radio_mode_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Measurement
  input  wire logic       start_in,
  input  wire logic       sample_valid_in,
  input  wire logic [3:0] sample_in,
  output logic            done_out,
  output logic [3:0]      value_out
);
  localparam int N = 1 << RSSI_AVG_LOG2;
  logic                     busy_r;
  logic [RSSI_AVG_LOG2:0]   cnt_r;
  logic [RSSI_AVG_LOG2+3:0] acc_r;
  // Single shot: average of N samples, value held until the next shot completes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      busy_r    <= 1'b0;
      cnt_r     <= '0;
      acc_r     <= '0;
      done_out  <= 1'b0;
      value_out <= RSSI_RST;
    end else if (start_in) begin
      busy_r   <= 1'b1;
      cnt_r    <= '0;
      acc_r    <= '0;
      done_out <= 1'b0;
    end else if (busy_r && sample_valid_in) begin
      acc_r <= acc_r + (RSSI_AVG_LOG2+4)'(sample_in);
      cnt_r <= cnt_r + 1'b1;
      if (cnt_r == (RSSI_AVG_LOG2+1)'(N - 1)) begin
        busy_r    <= 1'b0;
        done_out  <= 1'b1; // [RULE_15]
        value_out <= 4'((acc_r + (RSSI_AVG_LOG2+4)'(sample_in)) >> RSSI_AVG_LOG2);
      end
    end
  end
endmodule
`default_nettype wire

// file: src/radio_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
module radio_mode_controller
  import radio_mode_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int FIFO_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Start-up
  input  wire logic                  supply_ok_in,
  input  wire logic                  xtal_stable_in,
  output logic                       rc_osc_en_out,
  output logic                       xtal_en_out,
  output logic                       xtal_low_current_out,
  output logic                       irq_out,
  // Power management
  input  wire logic                  deep_sleep_bit_in,
  input  wire logic                  slow_standby_bit_in,
  output logic                       clocks_en_out,
  output logic                       slow_clk_out,
  // Mode requests
  input  wire logic                  tx_req_in,
  input  wire logic                  rx_req_in,
  input  wire logic                  exit_req_in,
  input  wire logic                  auto_ack_in,
  // Radio settings
  input  wire logic [7:0]            radio_warmup_time_in,
  input  wire logic [2:0]            tx_level_sel_in,
  input  wire logic [5:0]            channel_sel_in,
  output logic [5:0]                 channel_out,
  output logic [11:0]                freq_mhz_out,
  output logic signed [5:0]          tx_dbm_out,
  output logic [2:0]                 mode_out,
  output logic                       radio_ready_out,
  output logic                       tx_chain_en_out,
  output logic                       rx_chain_en_out,
  // Air side
  input  wire logic                  air_bit_in,
  input  wire logic                  rx_pkt_ok_in,
  output logic                       air_bit_out,
  output logic                       bit_strobe_out,
  output logic                       pkt_sent_out,
  output logic                       pkt_recv_out,
  // Transmit data stream
  input  wire logic                  tx_valid_in,
  output logic                       tx_ready_out,
  input  wire logic [FIFO_WIDTH-1:0] tx_data_in,
  // Signal strength
  input  wire logic                  rssi_start_in,
  input  wire logic                  rssi_sample_valid_in,
  input  wire logic [3:0]            rssi_sample_in,
  output logic                       rssi_done_out,
  output logic [3:0]                 signal_strength_value_out
);
  localparam int BW = $clog2(FIFO_WIDTH);

  function automatic logic [5:0] clamp_chan(input logic [5:0] c);
    return (c > CHAN_MAX) ? CHAN_MAX : c; // [RULE_13]
  endfunction

  function automatic logic signed [5:0] level_dbm(input logic [2:0] s);
    case (s) // [RULE_12]
      3'h7:    return 6'sd3;
      3'h6:    return 6'sd0;
      3'h5:    return -6'sd3;
      3'h4:    return -6'sd6;
      3'h3:    return -6'sd9;
      3'h2:    return -6'sd11;
      3'h1:    return -6'sd15;
      default: return -6'sd18;
    endcase
  endfunction

  mode_t            mode_r;
  mode_t            mode_nxt;
  startup_t         su_r;
  logic [15:0]      wait_r;
  logic             ready_r;
  logic             in_pkt_r;
  logic             ack_phase_r;
  logic [5:0]       bit_cnt_r;
  logic [BW-1:0]    bit_idx_r;
  logic [FIFO_WIDTH-1:0] shreg_r;
  logic             bits_left_r;
  logic [15:0]      slow_cnt_r;
  logic             fifo_valid;
  logic             fifo_pop;
  logic [FIFO_WIDTH-1:0] fifo_data;
  logic             bit_tick;
  logic             tx_done;
  logic             rx_done;
  logic             rssi_done;
  logic [3:0]       rssi_val;

  packet_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  rssi_meter u_rssi (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .start_in        (rssi_start_in && mode_r == MODE_RX),
    .sample_valid_in (rssi_sample_valid_in),
    .sample_in       (rssi_sample_in),
    .done_out        (rssi_done),
    .value_out       (rssi_val)
  );

  // Start-up sequencer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      su_r <= SU_RC;
    end else begin
      case (su_r)
        SU_RC:   if (supply_ok_in) su_r <= SU_XTAL; // [RULE_02]
        SU_XTAL: if (xtal_stable_in) su_r <= SU_DONE; // [RULE_02]
        SU_DONE: su_r <= SU_DONE;
        default: su_r <= SU_RC;
      endcase
    end
  end

  // Bit timer at the fixed air rate
  assign bit_tick = ready_r && (bit_cnt_r == 6'(BIT_CYC - 1));
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !ready_r) begin
      bit_cnt_r <= '0;
    end else begin
      bit_cnt_r <= bit_tick ? '0 : bit_cnt_r + 1'b1; // [RULE_16]
    end
  end

  // Packet ends when the FIFO runs dry in transmit
  assign fifo_pop = (mode_r == MODE_TX) && ready_r && !ack_phase_r && bit_tick
                    && (!bits_left_r || bit_idx_r == BW'(FIFO_WIDTH - 1)) && fifo_valid;
  // Ack reply carries no payload, so it ends on its first bit slot
  assign tx_done  = (mode_r == MODE_TX) && ready_r && bit_tick && (ack_phase_r
                    || (in_pkt_r && bit_idx_r == BW'(FIFO_WIDTH - 1) && !fifo_valid));
  assign rx_done  = (mode_r == MODE_RX) && ready_r && rx_pkt_ok_in;

  // Serializer, LSB first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || mode_r != MODE_TX) begin
      shreg_r     <= '0;
      bit_idx_r   <= '0;
      bits_left_r <= 1'b0;
      in_pkt_r    <= 1'b0;
    end else if (fifo_pop) begin
      shreg_r     <= fifo_data;
      bit_idx_r   <= '0;
      bits_left_r <= 1'b1;
      in_pkt_r    <= 1'b1;
    end else if (bit_tick && bits_left_r) begin
      shreg_r   <= shreg_r >> 1;
      bit_idx_r <= bit_idx_r + 1'b1;
      if (bit_idx_r == BW'(FIFO_WIDTH - 1)) begin
        bits_left_r <= 1'b0;
      end
    end
  end

  // Mode transitions
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_STARTUP: if (su_r == SU_DONE) mode_nxt = MODE_STANDBY; // [RULE_01]
      MODE_STANDBY: begin
        if (deep_sleep_bit_in) mode_nxt = MODE_SLEEP; // [RULE_03]
        else if (slow_standby_bit_in) mode_nxt = MODE_SLOW; // [RULE_04]
        else if (tx_req_in) mode_nxt = MODE_TX; // [RULE_06]
        else if (rx_req_in) mode_nxt = MODE_RX; // [RULE_08]
      end
      MODE_SLEEP: if (!deep_sleep_bit_in) mode_nxt = MODE_STANDBY; // [RULE_18]
      MODE_SLOW:  if (!slow_standby_bit_in) mode_nxt = MODE_STANDBY; // [RULE_18]
      MODE_TX: begin
        if (tx_done) mode_nxt = auto_ack_in && !ack_phase_r ? MODE_RX : MODE_STANDBY; // [RULE_07]
      end
      MODE_RX: begin
        if (exit_req_in) mode_nxt = MODE_STANDBY; // [RULE_09]
        else if (rx_done && ack_phase_r) mode_nxt = MODE_STANDBY; // [RULE_07]
        else if (rx_done && auto_ack_in) mode_nxt = MODE_TX; // [RULE_09]
      end
      default: mode_nxt = MODE_STANDBY;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_r <= MODE_STARTUP;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Ack exchange: set when transmit hands over to receive, or receive to transmit, for ack
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || mode_nxt == MODE_STANDBY) begin
      ack_phase_r <= 1'b0;
    end else if (mode_r != mode_nxt && (mode_r == MODE_TX || mode_r == MODE_RX)) begin
      ack_phase_r <= 1'b1;
    end
  end

  // Warm-up from standby, fixed turnaround between tx and rx
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_r  <= '0;
      ready_r <= 1'b0;
    end else if (mode_r != mode_nxt) begin
      ready_r <= 1'b0;
      if (mode_r == MODE_STANDBY) begin
        wait_r <= 16'(radio_warmup_time_in * WARMUP_UNIT_CYC); // [RULE_10]
      end else begin
        wait_r <= 16'(TURN_CYC); // [RULE_11]
      end
    end else if (mode_r == MODE_TX || mode_r == MODE_RX) begin
      if (wait_r > 16'h0001) begin
        wait_r <= wait_r - 1'b1;
      end else begin
        ready_r <= 1'b1; // [RULE_10]
      end
    end
  end

  // Slow system clock divider for low-power standby
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || mode_r != MODE_SLOW) begin
      slow_cnt_r   <= '0;
      slow_clk_out <= 1'b0;
    end else if (slow_cnt_r == 16'(SLOW_DIV - 1)) begin
      slow_cnt_r   <= '0;
      slow_clk_out <= ~slow_clk_out; // [RULE_04]
    end else begin
      slow_cnt_r <= slow_cnt_r + 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rc_osc_en_out        <= 1'b1;
      xtal_en_out          <= 1'b0;
      xtal_low_current_out <= 1'b0;
      irq_out              <= 1'b0;
      clocks_en_out        <= 1'b0;
      channel_out          <= CHAN_RST;
      freq_mhz_out         <= FREQ_BASE_MHZ;
      tx_dbm_out           <= level_dbm(LEVEL_RST);
      mode_out             <= 3'(MODE_STARTUP);
      radio_ready_out      <= 1'b0;
      tx_chain_en_out      <= 1'b0;
      rx_chain_en_out      <= 1'b0;
      air_bit_out          <= 1'b0;
      bit_strobe_out       <= 1'b0;
      pkt_sent_out         <= 1'b0;
      pkt_recv_out         <= 1'b0;
      rssi_done_out        <= 1'b0;
      signal_strength_value_out <= RSSI_RST;
    end else begin
      rc_osc_en_out <= (su_r != SU_DONE); // [RULE_02]
      xtal_en_out   <= (su_r != SU_RC) && (mode_r != MODE_SLEEP); // [RULE_02] [RULE_03] [RULE_05]
      xtal_low_current_out <= (mode_r == MODE_SLOW); // [RULE_04]
      irq_out       <= (mode_r == MODE_STARTUP) && (su_r == SU_DONE); // [RULE_02]
      clocks_en_out <= (mode_r == MODE_TX) || (mode_r == MODE_RX); // [RULE_03] [RULE_05]
      channel_out   <= clamp_chan(channel_sel_in); // [RULE_13]
      freq_mhz_out  <= FREQ_BASE_MHZ + {5'h00, clamp_chan(channel_sel_in), 1'b0}; // [RULE_14]
      tx_dbm_out    <= level_dbm(tx_level_sel_in); // [RULE_12]
      mode_out      <= 3'(mode_r);
      radio_ready_out <= ready_r; // [RULE_10]
      tx_chain_en_out <= (mode_r == MODE_TX);
      rx_chain_en_out <= (mode_r == MODE_RX);
      air_bit_out     <= (mode_r == MODE_TX) ? shreg_r[0] : air_bit_in; // [RULE_16] [RULE_17]
      bit_strobe_out  <= bit_tick && (mode_r != MODE_TX || bits_left_r); // [RULE_16]
      pkt_sent_out    <= tx_done; // [RULE_07]
      pkt_recv_out    <= rx_done;
      // Strength exposed only once the shot has finished
      rssi_done_out   <= rssi_done; // [RULE_15]
      if (rssi_done) begin
        signal_strength_value_out <= rssi_val; // [RULE_15]
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/radio_mode_checker.sv
`timescale 1ns/1ps
`default_nettype none
module radio_mode_checker
  import radio_mode_pkg::*;
(
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  // Watched ports
  input wire logic              irq_out,
  input wire logic              rc_osc_en_out,
  input wire logic              xtal_en_out,
  input wire logic              xtal_low_current_out,
  input wire logic              clocks_en_out,
  input wire logic              slow_clk_out,
  input wire logic              auto_ack_in,
  input wire logic [7:0]        radio_warmup_time_in,
  input wire logic [2:0]        tx_level_sel_in,
  input wire logic [5:0]        channel_out,
  input wire logic [11:0]       freq_mhz_out,
  input wire logic signed [5:0] tx_dbm_out,
  input wire logic [2:0]        mode_out,
  input wire logic              radio_ready_out,
  input wire logic              pkt_sent_out
);
  localparam logic [47:0] DBM_TAB = {6'h03, 6'h00, 6'h3D, 6'h3A, 6'h37, 6'h35, 6'h31, 6'h2E};
  logic        arm_r;
  logic [15:0] wait_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Armed only from standby, so ack turnaround is not counted
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || radio_ready_out) begin
      arm_r  <= 1'b0;
      wait_r <= 16'h0000;
    end else if (mode_out == 3'h1) begin
      arm_r  <= 1'b1;
      wait_r <= 16'h0000;
    end else if (arm_r && mode_out inside {3'h4, 3'h5}) begin
      wait_r <= wait_r + 16'h0001;
    end else begin
      arm_r <= 1'b0;
    end
  end
  AST_START_STANDBY: assert property ($rose(irq_out) |-> ##[0:2] mode_out == 3'h1)
    else $error("start-up did not end in standby");
  AST_IRQ_PULSE: assert property (irq_out |-> xtal_en_out ##1 !irq_out)
    else $error("start-up interrupt wrong");
  AST_RC_STOP: assert property (irq_out |-> ##[0:3] !rc_osc_en_out)
    else $error("rc clock not stopped");
  AST_SLEEP_CLOCKS: assert property ($stable(mode_out) && mode_out == 3'h2 |-> !clocks_en_out && !xtal_en_out)
    else $error("clocks run in power-down");
  AST_SLOW_XTAL: assert property ($stable(mode_out) && mode_out == 3'h3 |-> xtal_en_out && xtal_low_current_out)
    else $error("slow standby crystal wrong");
  AST_STANDBY_IDLE: assert property ($stable(mode_out) && mode_out == 3'h1 |-> xtal_en_out && !clocks_en_out && !slow_clk_out)
    else $error("standby not idle");
  AST_TX_ENTRY: assert property ($changed(mode_out) && mode_out == 3'h4 |-> $past(mode_out) inside {3'h1, 3'h5})
    else $error("transmit entered from wrong mode");
  AST_RX_ENTRY: assert property ($changed(mode_out) && mode_out == 3'h5 |-> $past(mode_out) inside {3'h1, 3'h4})
    else $error("receive entered from wrong mode");
  AST_SENT_NO_ACK: assert property (pkt_sent_out && !auto_ack_in && mode_out == 3'h4 |-> ##[1:3] mode_out == 3'h1)
    else $error("no return to standby after packet");
  AST_READY_TIME: assert property (int'(wait_r) <= int'(radio_warmup_time_in) * WARMUP_UNIT_CYC + 3)
    else $error("radio ready too late");
  AST_CHAN_CLAMP: assert property (channel_out <= CHAN_MAX)
    else $error("channel above limit");
  AST_FREQ_MAP: assert property ($stable(channel_out) [*3] |-> freq_mhz_out == FREQ_BASE_MHZ + {5'h00, channel_out, 1'b0})
    else $error("frequency mapping wrong");
  AST_LEVEL_MAP: assert property ($stable(tx_level_sel_in) [*3] |-> $unsigned(tx_dbm_out) == DBM_TAB[int'(tx_level_sel_in) * 6 +: 6])
    else $error("output level wrong");
  COV_IRQ: cover property ($rose(irq_out));
  COV_SENT: cover property (pkt_sent_out);
  COV_SLEEP: cover property (mode_out == 3'h2);
  COV_ACK_RX: cover property ($past(mode_out) == 3'h4 && mode_out == 3'h5);
endmodule
bind radio_mode_controller radio_mode_checker u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .irq_out(irq_out), .rc_osc_en_out(rc_osc_en_out),
  .xtal_en_out(xtal_en_out), .xtal_low_current_out(xtal_low_current_out),
  .clocks_en_out(clocks_en_out), .slow_clk_out(slow_clk_out), .auto_ack_in(auto_ack_in),
  .radio_warmup_time_in(radio_warmup_time_in), .tx_level_sel_in(tx_level_sel_in),
  .channel_out(channel_out), .freq_mhz_out(freq_mhz_out), .tx_dbm_out(tx_dbm_out),
  .mode_out(mode_out), .radio_ready_out(radio_ready_out), .pkt_sent_out(pkt_sent_out)
);
`default_nettype wire

// file: bench/air_peer.sv
`timescale 1ns/1ps
`default_nettype none
module air_peer (
  // Clock
  input  wire logic        clk_in,
  // Air side
  input  wire logic        dut_bit_in,
  input  wire logic        dut_strobe_in,
  output logic             peer_bit_out,
  output logic             peer_ok_out,
  // Bench control
  input  wire logic        ok_req_in,
  output logic [7:0]       last_byte_out,
  output logic [15:0]      bit_count_out
);
  initial begin
    peer_bit_out  = 1'b0;
    peer_ok_out   = 1'b0;
    last_byte_out = 8'h00;
    bit_count_out = 16'h0000;
  end
  always @(posedge clk_in) begin
    peer_bit_out <= ~peer_bit_out; // Idle air toggles, no stale level
    peer_ok_out  <= ok_req_in;
    if (dut_strobe_in) begin
      last_byte_out <= {dut_bit_in, last_byte_out[7:1]};
      bit_count_out <= bit_count_out + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import radio_mode_pkg::*;
  localparam logic [47:0] DBM_TAB = {6'h03, 6'h00, 6'h3D, 6'h3A, 6'h37, 6'h35, 6'h31, 6'h2E};
  localparam logic [31:0] PAY = 32'h1D332211;
  localparam logic [29:0] CHS = {6'h3F, 6'h28, 6'h27, 6'h13, 6'h00};
  logic clk_in = 1'b0, rst_n_in = 1'b0, supply_ok_in = 1'b0, xtal_stable_in = 1'b0;
  logic deep_sleep_bit_in = 1'b0, slow_standby_bit_in = 1'b0, auto_ack_in = 1'b0;
  logic tx_req_in = 1'b0, rx_req_in = 1'b0, exit_req_in = 1'b0, ok_req = 1'b0;
  logic tx_valid_in = 1'b0, rssi_start_in = 1'b0, rssi_sample_valid_in = 1'b0;
  logic [7:0] radio_warmup_time_in = 8'h02, tx_data_in = 8'h00;
  logic [2:0] tx_level_sel_in = 3'h6;
  logic [5:0] channel_sel_in = 6'h00;
  logic [3:0] rssi_sample_in = 4'h0;
  logic rc_osc_en_out, xtal_en_out, xtal_low_current_out, irq_out, clocks_en_out, slow_clk_out;
  logic radio_ready_out, air_bit_out, bit_strobe_out, pkt_sent_out, tx_ready_out, rssi_done_out;
  logic air_bit_in, rx_pkt_ok_in, pkt_recv_out;
  logic [5:0] channel_out;
  logic signed [5:0] tx_dbm_out;
  logic [11:0] freq_mhz_out;
  logic [2:0] mode_out;
  logic [3:0] signal_strength_value_out;
  logic [7:0] last_byte;
  logic [15:0] bit_count;
  int errors = 0, comparisons = 0, cyc = 0;
  always #12.5 clk_in = ~clk_in;
  radio_mode_controller #(.FIFO_DEPTH(4), .FIFO_WIDTH(8)) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .supply_ok_in(supply_ok_in),
    .xtal_stable_in(xtal_stable_in), .rc_osc_en_out(rc_osc_en_out), .xtal_en_out(xtal_en_out),
    .xtal_low_current_out(xtal_low_current_out), .irq_out(irq_out),
    .deep_sleep_bit_in(deep_sleep_bit_in), .slow_standby_bit_in(slow_standby_bit_in),
    .clocks_en_out(clocks_en_out), .slow_clk_out(slow_clk_out), .tx_req_in(tx_req_in),
    .rx_req_in(rx_req_in), .exit_req_in(exit_req_in), .auto_ack_in(auto_ack_in),
    .radio_warmup_time_in(radio_warmup_time_in), .tx_level_sel_in(tx_level_sel_in),
    .channel_sel_in(channel_sel_in), .channel_out(channel_out), .freq_mhz_out(freq_mhz_out),
    .tx_dbm_out(tx_dbm_out), .mode_out(mode_out), .radio_ready_out(radio_ready_out),
    .tx_chain_en_out(), .rx_chain_en_out(), .air_bit_in(air_bit_in), .rx_pkt_ok_in(rx_pkt_ok_in),
    .air_bit_out(air_bit_out), .bit_strobe_out(bit_strobe_out), .pkt_sent_out(pkt_sent_out),
    .pkt_recv_out(pkt_recv_out), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .tx_data_in(tx_data_in), .rssi_start_in(rssi_start_in),
    .rssi_sample_valid_in(rssi_sample_valid_in), .rssi_sample_in(rssi_sample_in),
    .rssi_done_out(rssi_done_out), .signal_strength_value_out(signal_strength_value_out)
  );
  air_peer u_peer (
    .clk_in(clk_in), .dut_bit_in(air_bit_out), .dut_strobe_in(bit_strobe_out),
    .peer_bit_out(air_bit_in), .peer_ok_out(rx_pkt_ok_in), .ok_req_in(ok_req),
    .last_byte_out(last_byte), .bit_count_out(bit_count)
  );
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 9000 && mode_out !== m; i++) step(1);
    check("mode_out", {13'h0, mode_out}, {13'h0, m});
  endtask
  task automatic wait_hi(ref logic s, input string nm);
    for (int i = 0; i < 9000 && s !== 1'b1; i++) step(1);
    check(nm, {15'h0, s}, 16'h0001);
  endtask
  // Holds valid for eight cycles; data advances only on acceptance
  task automatic fill(output int n);
    n = 0;
    tx_valid_in = 1'b1;
    tx_data_in = PAY[7:0];
    repeat (8) begin
      if (tx_ready_out === 1'b1) n++;
      step(1);
      tx_data_in = PAY[(n % 4) * 8 +: 8];
    end
    tx_valid_in = 1'b0;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    int n, cnt, base;
    logic [5:0] ch;
    step(20);
    rst_n_in = 1'b1;
    step(1);
    check("mode_out", {13'h0, mode_out}, 16'h0000);
    check("rc_osc_en_out", {15'h0, rc_osc_en_out}, 16'h0001);
    supply_ok_in = 1'b1;
    step(4);
    check("xtal_en_out", {15'h0, xtal_en_out}, 16'h0001);
    xtal_stable_in = 1'b1;
    wait_hi(irq_out, "irq_out");
    wait_mode(3'h1);
    step(4);
    check("rc_osc_en_out", {15'h0, rc_osc_en_out}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      channel_sel_in = CHS[i * 6 +: 6];
      ch = (CHS[i * 6 +: 6] > 6'h27) ? 6'h27 : CHS[i * 6 +: 6];
      step(3);
      check("channel_out", {10'h0, channel_out}, {10'h0, ch});
      check("freq_mhz_out", {4'h0, freq_mhz_out}, 16'd2402 + {9'h0, ch, 1'b0});
    end
    for (int i = 0; i < 8; i++) begin
      tx_level_sel_in = 3'(i);
      step(3);
      check("tx_dbm_out", {10'h0, tx_dbm_out}, {10'h0, DBM_TAB[i * 6 +: 6]});
    end
    deep_sleep_bit_in = 1'b1;
    wait_mode(3'h2);
    pulse(tx_req_in);
    step(4);
    check("mode_out", {13'h0, mode_out}, 16'h0002);
    check("clocks", {14'h0, clocks_en_out, xtal_en_out}, 16'h0000);
    deep_sleep_bit_in = 1'b0;
    wait_mode(3'h1);
    slow_standby_bit_in = 1'b1;
    wait_mode(3'h3);
    cnt = 0;
    repeat (1000) begin
      n = slow_clk_out;
      step(1);
      if (n == 0 && slow_clk_out === 1'b1) cnt++;
    end
    check("slow_clk_rises", 16'(cnt), 16'd10);
    slow_standby_bit_in = 1'b0;
    wait_mode(3'h1);
    check("xtal_low_current_out", {15'h0, xtal_low_current_out}, 16'h0000);
    fill(n);
    check("fifo_accepted", 16'(n), 16'd4);
    base = bit_count;
    pulse(tx_req_in);
    wait_mode(3'h4);
    pulse(rx_req_in);
    step(2);
    check("mode_out", {13'h0, mode_out}, 16'h0004);
    wait_hi(radio_ready_out, "radio_ready_out");
    wait_hi(pkt_sent_out, "pkt_sent_out");
    wait_mode(3'h1);
    check("last_byte", {8'h0, last_byte}, {8'h0, PAY[31:24]});
    check("bit_count", bit_count - 16'(base), 16'd32);
    auto_ack_in = 1'b1;
    fill(n);
    pulse(tx_req_in);
    wait_hi(pkt_sent_out, "pkt_sent_out");
    wait_mode(3'h5);
    step(6100);
    pulse(ok_req);
    wait_mode(3'h1);
    pulse(rx_req_in);
    wait_mode(3'h5);
    wait_hi(radio_ready_out, "radio_ready_out");
    pulse(rssi_start_in);
    rssi_sample_in = 4'h9;
    rssi_sample_valid_in = 1'b1;
    step(16);
    rssi_sample_valid_in = 1'b0;
    wait_hi(rssi_done_out, "rssi_done_out");
    check("strength", {12'h0, signal_strength_value_out}, 16'h0009);
    pulse(ok_req);
    wait_mode(3'h4);
    for (cnt = 0; cnt < 9000 && radio_ready_out !== 1'b1; cnt++) step(1);
    check("turnaround_ok", {15'h0, cnt >= TURN_CYC - 2 && cnt <= TURN_CYC + 6}, 16'h0001);
    wait_mode(3'h1);
    auto_ack_in = 1'b0;
    pulse(rx_req_in);
    wait_mode(3'h5);
    wait_hi(radio_ready_out, "radio_ready_out");
    pulse(ok_req);
    wait_hi(pkt_recv_out, "pkt_recv_out");
    step(10);
    check("mode_out", {13'h0, mode_out}, 16'h0005);
    pulse(exit_req_in);
    wait_mode(3'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
